/* File: src/pbs_consts.vh */
// Constants for the pipelined burst SRAM port.
// Behaviour
// - Sleep is entered two clocks after the request rises, left two after it falls.
// - Sleep keeps stored words; accesses pending at sleep entry are dropped.
// - Sleep request ignores all other inputs and floats data and parity lines.
// - Burst order high steps the low address bits in interleaved order.
// - Burst order low steps the low address bits linearly, wrapping modulo four.
// - Selected only with all three chip selects active; otherwise load starts deselect.
// - Selected load with write strobe high starts a read burst at the pin address.
// - Advance during a read burst steps the counter regardless of selects and strobe.
// - Reads performed with output enable high are dummy reads, lines floating.
// - Selected load with strobe low and any byte select low starts a write burst.
// - Advance during a write burst steps the address and writes selected lanes.
// - Write start with all byte selects high is an abort: nothing written, but the address still loads the burst counter.
// - Write continuation with all byte selects high steps the address, writes nothing.
// - Outside sleep, clock qualifier high holds address and all pipeline state unchanged.
// - Any write cycle floats all data and parity lines, also for partial writes.
// - Data and parity lines follow the cycle now completing, gated by output enable.
// - After power-up the device is deselected with lines floating.
// - Output enable acts without the clock and is masked during writes.
// - Each low byte select writes its own lane and that lane's parity bit.
// - A write with every byte select high leaves stored bytes unchanged.
// - The burst counter gives four addresses from one loaded address, then wraps to the first.
// - Read or write direction is latched at burst start for the whole burst.
// - Read data leaves the output register after the next rising edge.
`ifndef PBS_CONSTS_VH
`define PBS_CONSTS_VH

// Clock period and sleep timing, in nanoseconds.
`define PBS_CLK_PERIOD_NS 40
`define PBS_SLEEP_ENTRY_NS 80
`define PBS_SLEEP_RECOVERY_NS 80

// Pipeline operation codes.
`define PBS_OP_W 2
`define PBS_OP_DESEL 2'h0
`define PBS_OP_READ 2'h1
`define PBS_OP_WRITE 2'h2
`define PBS_OP_ABORT 2'h3

// Burst counter width and wrap.
`define PBS_BURST_W 2
`define PBS_BURST_ZERO 2'h0
`define PBS_BURST_ONE 2'h1

// Default geometry.
`define PBS_ADDR_W 17
`define PBS_LANES 4
`define PBS_LANE_W 8

`endif

/* File: src/pbs_sram_port.v */
// Synchronous port logic and storage of a pipelined burst SRAM.
`timescale 1ns/1ps
`include "pbs_consts.vh"

module pbs_sram_port #(
  parameter ADDR_W = `PBS_ADDR_W,
  parameter LANES = `PBS_LANES,
  parameter LANE_W = `PBS_LANE_W
) (
  input wire SYS_CLK,
  input wire RESET,
  input wire CLOCK_QUALIFY_N,
  input wire [ADDR_W-1:0] ADDR,
  input wire CHIP_SELECT_FIRST_N,
  input wire CHIP_SELECT_SECOND,
  input wire CHIP_SELECT_THIRD_N,
  input wire ADVANCE_OR_LOAD,
  input wire WRITE_ENABLE_N,
  input wire [LANES-1:0] BYTE_WRITE_SELECT_N,
  input wire OUTPUT_ENABLE_N,
  input wire BURST_ORDER,
  input wire SLEEP_REQUEST,
  input wire [LANES*LANE_W-1:0] DATA_IN,
  output wire [LANES*LANE_W-1:0] DATA_OUT,
  output wire DATA_OE,
  input wire [LANES-1:0] PARITY_LINES_IN,
  output wire [LANES-1:0] PARITY_LINES_OUT,
  output wire PARITY_LINES_OE,
  output wire SLEEPING
);

  localparam DATA_W = LANES * LANE_W;
  localparam WORD_W = DATA_W + LANES;
  localparam DEPTH = 1 << ADDR_W;
  localparam SLEEP_ENTRY_CYC = `PBS_SLEEP_ENTRY_NS / `PBS_CLK_PERIOD_NS;
  localparam SLEEP_RECOVERY_CYC = `PBS_SLEEP_RECOVERY_NS / `PBS_CLK_PERIOD_NS;
  localparam SLEEP_CYC = (SLEEP_ENTRY_CYC > SLEEP_RECOVERY_CYC) ? SLEEP_ENTRY_CYC
                                                                 : SLEEP_RECOVERY_CYC;

  // Storage: each word holds the data lanes followed by one parity bit per lane.
  reg [WORD_W-1:0] mem [0:DEPTH-1];

  // Next low address bits for a burst from its start value and beat count.
  function [`PBS_BURST_W-1:0] burst_low;
    input [`PBS_BURST_W-1:0] start;
    input [`PBS_BURST_W-1:0] beat;
    input order;
    begin
      if (order) begin
        burst_low = start ^ beat;
      end else begin
        burst_low = start + beat;
      end
    end
  endfunction

  // Merge new lane data and parity into an old word under active-low selects.
  function [WORD_W-1:0] lane_merge;
    input [WORD_W-1:0] old_word;
    input [DATA_W-1:0] new_data;
    input [LANES-1:0] new_par;
    input [LANES-1:0] sel_n;
    integer i;
    integer b;
    begin
      lane_merge = old_word;
      for (i = 0; i < LANES; i = i + 1) begin
        if (!sel_n[i]) begin
          for (b = 0; b < LANE_W; b = b + 1) begin
            lane_merge[i*LANE_W+b] = new_data[i*LANE_W+b];
          end
          lane_merge[DATA_W+i] = new_par[i];
        end
      end
    end
  endfunction

  // Sleep request synchroniser and delay chain.
  reg [SLEEP_CYC-1:0] sleep_chain_q;
  wire sleeping;

  // Burst state.
  reg burst_act_q;
  reg burst_wr_q;
  reg [ADDR_W-1:0] burst_base_q;
  reg [`PBS_BURST_W-1:0] burst_start_q;
  reg [`PBS_BURST_W-1:0] burst_beat_q;
  reg burst_act_d;
  reg burst_wr_d;
  reg [ADDR_W-1:0] burst_base_d;
  reg [`PBS_BURST_W-1:0] burst_start_d;
  reg [`PBS_BURST_W-1:0] burst_beat_d;

  // First pipeline stage: cycle decoded at the command edge.
  reg [`PBS_OP_W-1:0] st1_op_q;
  reg [ADDR_W-1:0] st1_addr_q;
  reg [LANES-1:0] st1_sel_n_q;
  reg [`PBS_OP_W-1:0] st1_op_d;
  reg [ADDR_W-1:0] st1_addr_d;
  reg [LANES-1:0] st1_sel_n_d;

  // Second stage: write waiting for its data, and the output register.
  reg st2_wr_q;
  reg [ADDR_W-1:0] st2_addr_q;
  reg [LANES-1:0] st2_sel_n_q;
  reg out_rd_q;
  reg [WORD_W-1:0] out_q;

  wire selected;
  wire any_lane;
  wire [ADDR_W-1:0] next_addr;
  wire qualified;
  wire [WORD_W-1:0] rd_word;
  wire commit;

  // The first flop only feeds the second; the chain end is the sleep state.
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      sleep_chain_q <= {SLEEP_CYC{1'b0}};
    end else begin
      sleep_chain_q <= {sleep_chain_q[SLEEP_CYC-2:0], SLEEP_REQUEST};
    end
  end

  assign sleeping = sleep_chain_q[SLEEP_CYC-1];
  assign SLEEPING = sleeping;

  assign selected = ~CHIP_SELECT_FIRST_N & CHIP_SELECT_SECOND & ~CHIP_SELECT_THIRD_N;
  assign any_lane = ~&BYTE_WRITE_SELECT_N;

  // Address of the next beat; only the two low bits move, so a burst wraps.
  assign next_addr = {burst_base_q[ADDR_W-1:`PBS_BURST_W],
                      burst_low(burst_start_q, burst_beat_q + `PBS_BURST_ONE, BURST_ORDER)};

  // Outside sleep a stalled edge changes only the sleep chain, and sleep blocks every other input.
  assign qualified = ~CLOCK_QUALIFY_N & ~sleeping;

  // Decode of the command edge.
  always @* begin
    burst_act_d = burst_act_q;
    burst_wr_d = burst_wr_q;
    burst_base_d = burst_base_q;
    burst_start_d = burst_start_q;
    burst_beat_d = burst_beat_q;
    st1_op_d = `PBS_OP_DESEL;
    st1_addr_d = st1_addr_q;
    st1_sel_n_d = BYTE_WRITE_SELECT_N;
    if (ADVANCE_OR_LOAD) begin
      if (burst_act_q) begin
        // Chip selects and write strobe are ignored while advancing.
        burst_beat_d = burst_beat_q + `PBS_BURST_ONE;
        st1_addr_d = next_addr;
        if (!burst_wr_q) begin
          st1_op_d = `PBS_OP_READ;
        end else if (any_lane) begin
          st1_op_d = `PBS_OP_WRITE;
        end else begin
          st1_op_d = `PBS_OP_ABORT;
        end
      end else begin
        st1_op_d = `PBS_OP_DESEL;
      end
    end else if (!selected) begin
      burst_act_d = 1'b0;
      st1_op_d = `PBS_OP_DESEL;
    end else begin
      burst_act_d = 1'b1;
      burst_wr_d = ~WRITE_ENABLE_N;
      burst_base_d = ADDR;
      burst_start_d = ADDR[`PBS_BURST_W-1:0];
      burst_beat_d = `PBS_BURST_ZERO;
      st1_addr_d = ADDR;
      if (WRITE_ENABLE_N) begin
        st1_op_d = `PBS_OP_READ;
      end else if (any_lane) begin
        st1_op_d = `PBS_OP_WRITE;
      end else begin
        // Nothing reaches the array, so the stage keeps its old address; the burst base still loads.
        st1_op_d = `PBS_OP_ABORT;
        st1_addr_d = st1_addr_q;
      end
    end
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      burst_act_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_base_q <= {ADDR_W{1'b0}};
      burst_start_q <= `PBS_BURST_ZERO;
      burst_beat_q <= `PBS_BURST_ZERO;
      st1_op_q <= `PBS_OP_DESEL;
      st1_addr_q <= {ADDR_W{1'b0}};
      st1_sel_n_q <= {LANES{1'b1}};
    end else if (sleeping) begin
      // A burst or command in flight at sleep entry is simply abandoned.
      burst_act_q <= 1'b0;
      st1_op_q <= `PBS_OP_DESEL;
    end else if (qualified) begin
      burst_act_q <= burst_act_d;
      burst_wr_q <= burst_wr_d;
      burst_base_q <= burst_base_d;
      burst_start_q <= burst_start_d;
      burst_beat_q <= burst_beat_d;
      st1_op_q <= st1_op_d;
      st1_addr_q <= st1_addr_d;
      st1_sel_n_q <= st1_sel_n_d;
    end
  end

  // The write being committed at this edge lands in the array only now, so
  // a read of the same word one stage behind sees the merged value instead.
  assign commit = qualified & st2_wr_q;
  assign rd_word = (commit && st2_addr_q == st1_addr_q) ?
                   lane_merge(mem[st1_addr_q], DATA_IN, PARITY_LINES_IN, st2_sel_n_q) :
                   mem[st1_addr_q];

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      st2_wr_q <= 1'b0;
      st2_addr_q <= {ADDR_W{1'b0}};
      st2_sel_n_q <= {LANES{1'b1}};
      out_rd_q <= 1'b0;
      out_q <= {WORD_W{1'b0}};
    end else if (sleeping) begin
      st2_wr_q <= 1'b0;
      out_rd_q <= 1'b0;
    end else if (qualified) begin
      st2_wr_q <= (st1_op_q == `PBS_OP_WRITE);
      st2_addr_q <= st1_addr_q;
      st2_sel_n_q <= st1_sel_n_q;
      out_rd_q <= (st1_op_q == `PBS_OP_READ);
      if (st1_op_q == `PBS_OP_READ) begin
        out_q <= rd_word;
      end
    end
  end

  // Write data arrives two edges after its command and is taken here.
  always @(posedge SYS_CLK) begin
    if (commit) begin
      mem[st2_addr_q] <= lane_merge(mem[st2_addr_q], DATA_IN, PARITY_LINES_IN, st2_sel_n_q);
    end
  end

  // Output enable gates the drivers without the clock; a write or abort in
  // the completing slot leaves out_rd_q low, which masks it. Sleep uses the
  // synchronised level, so the lines float once entry has completed.
  assign DATA_OE = out_rd_q & ~OUTPUT_ENABLE_N & ~sleeping;
  assign PARITY_LINES_OE = out_rd_q & ~OUTPUT_ENABLE_N & ~sleeping;
  assign DATA_OUT = out_q[DATA_W-1:0];
  assign PARITY_LINES_OUT = out_q[WORD_W-1:DATA_W];

endmodule

/* File: test/pbs_ctrl_model.sv */
// Controller-side model that drives write data and parity for the burst SRAM port.
`timescale 1ns/1ps
module pbs_ctrl_model (
  input wire logic clk,
  input wire logic qual_n,
  input wire logic wr,
  input wire logic [31:0] wd,
  output logic [31:0] data_in,
  output logic [3:0] par_in
);
  logic p_q = 1'b0;
  logic [31:0] d_q = 32'h0;
  initial {data_in, par_in} = 36'h0;
  always @(posedge clk) begin
    if (!qual_n) begin
      {p_q, d_q} <= {wr, wd};
      // Outside a data phase the lines toggle, so a stale word can never pass for data.
      data_in <= p_q ? d_q : ~data_in;
      par_in <= p_q ? {^d_q[31:24], ^d_q[23:16], ^d_q[15:8], ^d_q[7:0]} : ~par_in;
    end
  end
endmodule

/* File: test/pbs_sram_port_assertions.sv */
// Port checks for the burst SRAM port.
`timescale 1ns/1ps
module pbs_sram_port_assertions #(parameter LANES = 4, parameter LANE_W = 8) (
  input wire SYS_CLK,
  input wire RESET,
  input wire CLOCK_QUALIFY_N,
  input wire CHIP_SELECT_FIRST_N,
  input wire CHIP_SELECT_SECOND,
  input wire CHIP_SELECT_THIRD_N,
  input wire ADVANCE_OR_LOAD,
  input wire WRITE_ENABLE_N,
  input wire OUTPUT_ENABLE_N,
  input wire SLEEP_REQUEST,
  input wire [LANES*LANE_W-1:0] DATA_OUT,
  input wire DATA_OE,
  input wire PARITY_LINES_OE,
  input wire SLEEPING
);
  wire sel = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND && !CHIP_SELECT_THIRD_N;
  wire go = !CLOCK_QUALIFY_N && !SLEEP_REQUEST && !SLEEPING;
  wire ld = go && !ADVANCE_OR_LOAD;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sequence s_rd; ld && sel && WRITE_ENABLE_N ##1 go; endsequence
  sequence s_wr; ld && sel && !WRITE_ENABLE_N ##1 go; endsequence
  sequence s_up; $rose(SLEEP_REQUEST) ##1 SLEEP_REQUEST; endsequence
  sequence s_down; $fell(SLEEP_REQUEST) ##1 !SLEEP_REQUEST; endsequence
  AST_READ_DRIVES: assert property (s_rd |=> DATA_OE == !OUTPUT_ENABLE_N)
    else $error("read not driven");
  AST_WRITE_FLOATS: assert property (s_wr |=> !DATA_OE && !PARITY_LINES_OE)
    else $error("write drove lines");
  AST_DESEL_FLOATS: assert property (ld && !sel ##1 go |=> !DATA_OE)
    else $error("deselect drove lines");
  AST_OE_GATES: assert property (OUTPUT_ENABLE_N |-> !DATA_OE)
    else $error("drive with enable off");
  AST_PARITY_PAIR: assert property (DATA_OE == PARITY_LINES_OE)
    else $error("parity enable differs");
  AST_SLEEP_ENTRY: assert property (s_up |-> !SLEEPING ##1 SLEEPING)
    else $error("sleep entry timing");
  AST_SLEEP_EXIT: assert property (s_down |-> SLEEPING ##1 !SLEEPING)
    else $error("sleep exit timing");
  AST_SLEEP_FLOATS: assert property (SLEEPING |-> !DATA_OE)
    else $error("drive while asleep");
  AST_STALL_HOLDS: assert property (CLOCK_QUALIFY_N && !SLEEP_REQUEST && !SLEEPING |=> $stable(DATA_OUT))
    else $error("stall moved data");
endmodule
bind pbs_sram_port pbs_sram_port_assertions #(.LANES(LANES), .LANE_W(LANE_W)) u_chk (.SYS_CLK(SYS_CLK),
  .RESET(RESET), .CLOCK_QUALIFY_N(CLOCK_QUALIFY_N), .CHIP_SELECT_FIRST_N(CHIP_SELECT_FIRST_N),
  .CHIP_SELECT_SECOND(CHIP_SELECT_SECOND), .CHIP_SELECT_THIRD_N(CHIP_SELECT_THIRD_N),
  .ADVANCE_OR_LOAD(ADVANCE_OR_LOAD), .WRITE_ENABLE_N(WRITE_ENABLE_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
  .SLEEP_REQUEST(SLEEP_REQUEST), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .PARITY_LINES_OE(PARITY_LINES_OE),
  .SLEEPING(SLEEPING));

/* File: test/pbs_sram_port_bench.sv */
// Self-checking bench for the burst SRAM port.
`timescale 1ns/1ps
module pbs_sram_port_bench;
  logic clk = 0, rst = 1, qn = 0, adv = 0, c1n = 1, c2 = 0, c3n = 1, wen = 1, oen = 0, mode = 0, zz = 0, wr = 0;
  logic oe_set = 0, zz_set = 0, mode_set = 0, pstall = 0, doe, poe, slp;
  logic [16:0] addr = 0;
  logic [3:0] bwn = 4'hf, pin, pout;
  logic [31:0] din, dout, wd = 0;
  logic [38:0] p1 = 0, p2 = 0, pend = 0;
  logic [31:0] mem [logic [16:0]];
  int num_errors = 0, checked = 0, cyc = 0;
  pbs_sram_port DUT (.SYS_CLK(clk), .RESET(rst), .CLOCK_QUALIFY_N(qn), .ADDR(addr), .CHIP_SELECT_FIRST_N(c1n),
    .CHIP_SELECT_SECOND(c2), .CHIP_SELECT_THIRD_N(c3n), .ADVANCE_OR_LOAD(adv), .WRITE_ENABLE_N(wen),
    .BYTE_WRITE_SELECT_N(bwn), .OUTPUT_ENABLE_N(oen), .BURST_ORDER(mode), .SLEEP_REQUEST(zz), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE(doe), .PARITY_LINES_IN(pin), .PARITY_LINES_OUT(pout), .PARITY_LINES_OE(poe),
    .SLEEPING(slp));
  pbs_ctrl_model u_ctrl (.clk(clk), .qual_n(qn), .wr(wr), .wd(wd), .data_in(din), .par_in(pin));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1500) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic check(input logic [37:0] seen, input logic [37:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [38:0] rd(input logic [16:0] a);
    return {3'b111, ^mem[a][31:24], ^mem[a][23:16], ^mem[a][15:8], ^mem[a][7:0], mem[a]};
  endfunction
  // One command per edge; e is what the lines must show two qualified edges later.
  task automatic op(input logic a, s, w, input logic [3:0] b, input logic [16:0] ad, input logic [31:0] d,
                    input logic [38:0] e, input logic st = 0);
    @(posedge clk);
    {qn, adv, wen, bwn, addr, oen, zz, mode} <= {st, a, w, b, ad, oe_set, zz_set, mode_set};
    {c1n, c2, c3n, wr, wd} <= {!s, s, !s, !w, d};
    if (!pstall) {p2, p1} = {p1, pend};
    {pend, pstall} = {e, st};
    #1;
    if (p2[38]) check(doe ? {1'b1, poe, pout, dout} : 38'h0, oen ? 38'h0 : p2[37:0]);
  endtask
  task automatic idle(input int n);
    repeat (n) op(0, 0, 1, 4'hf, 17'h0, 0, {1'b1, 38'h0});
  endtask
  task automatic burst(input logic w, input logic [16:0] a, input logic o, input logic [15:0] bw,
                       input logic [31:0] d0, input int n);
    logic [16:0] ad;
    logic [31:0] m;
    mode_set = o;
    for (int b = 0; b < n; b++) begin
      ad = {a[16:2], o ? a[1:0] ^ 2'(b) : a[1:0] + 2'(b)};
      m = mem.exists(ad) ? mem[ad] : 32'h0;
      for (int k = 0; k < 4; k++) if (!w && !bw[4*b+k]) m[8*k +: 8] = 8'(d0 + b * 32'h01010101 >> 8*k);
      if (!w) mem[ad] = m;
      op(b != 0, b == 0, w, bw[4*b +: 4], b ? ~ad : ad, d0 + b * 32'h01010101, w ? rd(ad) : {1'b1, 38'h0});
    end
  endtask
  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    #1 check({doe, poe, slp}, 0);
    for (int i = 0; i < 8; i++) burst(0, 17'h40 + i, 0, 16'h0, 32'h10000000 + i * 32'h00130007, 1);
    for (int o = 0; o < 2; o++) for (int s = 0; s < 4; s++) burst(1, 17'h40 + s, o, 16'hffff, 0, 4);
    $display("test burst order done");
    burst(0, 17'h46, 1, 16'h0afe, 32'ha5c30f96, 4);
    burst(0, 17'h41, 0, 16'hffff, 32'hdeadbeef, 2);
    burst(1, 17'h44, 0, 16'hffff, 0, 4);
    $display("test byte writes done");
    op(0, 1, 1, 4'hf, 17'h40, 0, rd(17'h40));
    op(1, 0, 1, 4'hf, 17'h0, 0, 0, 1);
    op(1, 0, 1, 4'hf, 17'h0, 0, rd(17'h41));
    // Let the stalled read data leave the pipeline while output enable is still low, so its value is compared.
    idle(2);
    oe_set = 1;
    burst(1, 17'h42, 1, 16'hffff, 0, 2);
    idle(2);
    oe_set = 0;
    idle(2);
    $display("test stall and dummy read done");
    zz_set = 1;
    idle(4);
    check(slp, 1);
    op(0, 1, 0, 4'h0, 17'h40, 32'hffffffff, {1'b1, 38'h0});
    zz_set = 0;
    idle(4);
    burst(1, 17'h40, 0, 16'hffff, 0, 1);
    idle(2);
    $display("test sleep done");
    complete_run();
  end
endmodule
